// file: design/sec_eeprom.sv
`timescale 1ns/1ns
`default_nettype none
module sec_eeprom #(
    parameter int ADDR_W = sec_pkg::ADDR_BITS,
    parameter int WR_CYC = sec_pkg::WR_CYCLES
) (
    // System clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Serial link.
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe,
    // Protect pin.
    input wire logic wp_n,
    // Status bits.
    output logic write_latch,
    output logic busy,
    output logic [2:0] block_protect,
    output logic hw_protect_arm
);
    import sec_pkg::*;

    localparam int NWORDS = (2 ** ADDR_W) / GROUP_BYTES;
    localparam int WA_W = ADDR_W - 2;
    localparam int PAGE_WORDS = PAGE_BYTES / GROUP_BYTES;
    localparam int PW_BITS = $clog2(PAGE_WORDS);
    localparam int CNT_W = $clog2(WR_CYC + 1);
    localparam int WORD_W = ECC_BITS + DATA_BITS;

    typedef struct packed {
        logic cs1;
        logic cs2;
        logic cs3;
        logic wp1;
        logic wp2;
        logic wen;
        logic [2:0] bp;
        logic arm;
        logic busy;
        logic pend_sr;
        logic [CNT_W-1:0] cnt;
        logic [2:0] new_bp;
        logic new_arm;
        logic [NWORDS-1:0][WORD_W-1:0] mem;
    } sec_core_t;

    typedef struct packed {
        sec_phase_t phase;
        sec_cmd_t cmd;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic got;
        logic [ADDR_W-1:0] addr;
        logic [PAGE_BYTES-1:0][7:0] pbuf;
        logic [PAGE_BYTES-1:0] mask;
    } sec_link_t;

    sec_core_t c;
    sec_core_t next_c;
    sec_link_t l;
    sec_link_t next_l;
    logic in_frame;
    logic [7:0] status_view;
    logic [7:0] out_byte;
    logic cs_rise;

    // Check-bit position of a data bit: the non-power-of-two slots in order.
    function automatic logic [5:0] ecc_pos(input int j);
        int n;
        logic [5:0] p;
        n = 0;
        p = 6'h0;
        for (int k = 3; k < 64; k++) begin
            if ((k & (k - 1)) != 0) begin
                if (n == j) begin
                    p = 6'(k);
                end
                n = n + 1;
            end
        end
        return p;
    endfunction

    function automatic logic [ECC_BITS-1:0] ecc_gen(input logic [DATA_BITS-1:0] d);
        logic [ECC_BITS-1:0] s;
        s = '0;
        for (int j = 0; j < DATA_BITS; j++) begin
            if (d[j]) begin
                s = s ^ ecc_pos(j);
            end
        end
        return s;
    endfunction

    function automatic logic [DATA_BITS-1:0] ecc_fix(input logic [WORD_W-1:0] w);
        logic [DATA_BITS-1:0] d;
        logic [ECC_BITS-1:0] s;
        d = w[DATA_BITS-1:0];
        s = ecc_gen(d) ^ w[WORD_W-1:DATA_BITS];
        for (int j = 0; j < DATA_BITS; j++) begin
            if (s == ecc_pos(j)) begin
                d[j] = ~d[j];
            end
        end
        return d;
    endfunction

    // Protected ranges by the two low protect bits: none, top quarter, top half, all.
    function automatic logic in_block(input logic [ADDR_W-1:0] a, input logic [2:0] bp);
        case (bp[1:0])
            2'h1: return a[ADDR_W-1] & a[ADDR_W-2];
            2'h2: return a[ADDR_W-1];
            2'h3: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Status byte; all ones while a write cycle runs.
    always_comb begin
        status_view = '0;
        status_view[ST_WEN] = c.wen;
        status_view[ST_BP_LO +: 3] = c.bp;
        status_view[ST_ARM] = c.arm;
        if (c.busy) begin
            status_view = ST_BUSY_VIEW;
        end
    end

    // Frame marker: cleared by chip select, so a raised select stops any transfer.
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    // Link side: opcode, address and data are taken on rising serial clock edges.
    always_comb begin
        sec_link_t cur;
        logic [7:0] byte_in;
        sec_cmd_t dec;
        byte_in = {l.sh[6:0], spi_si};
        dec = sec_decode(byte_in);
        cur = l;
        if (!in_frame) begin
            cur.phase = PH_OP;
            cur.cmd = CMD_NONE;
            cur.bcnt = '0;
            cur.got = 1'b0;
            cur.mask = '0;
        end
        next_l = cur;
        case (cur.phase)
            PH_OP: begin
                next_l.sh = byte_in;
                next_l.bcnt = cur.bcnt + 4'h1;
                if (cur.bcnt[2:0] == 3'h7) begin
                    next_l.bcnt = '0;
                    next_l.cmd = dec;
                    if (status_view[ST_BUSY] && dec != CMD_SRD) begin
                        next_l.cmd = CMD_NONE;
                        next_l.phase = PH_SKIP;
                    end else begin
                        case (dec)
                            CMD_SRD: next_l.phase = PH_OUT;
                            CMD_SWR: next_l.phase = PH_DATA;
                            CMD_RD: next_l.phase = PH_ADDR;
                            CMD_WR: next_l.phase = PH_ADDR;
                            default: next_l.phase = PH_SKIP;
                        endcase
                    end
                end
            end
            PH_ADDR: begin
                next_l.addr = {cur.addr[ADDR_W-2:0], spi_si};
                next_l.bcnt = cur.bcnt + 4'h1;
                if (cur.bcnt == 4'hf) begin
                    next_l.phase = (cur.cmd == CMD_RD) ? PH_OUT : PH_DATA;
                end
            end
            PH_DATA: begin
                next_l.sh = byte_in;
                next_l.bcnt = cur.bcnt + 4'h1;
                if (cur.bcnt[2:0] == 3'h7) begin
                    next_l.bcnt = '0;
                    next_l.got = 1'b1;
                    if (cur.cmd == CMD_WR) begin
                        next_l.pbuf[cur.addr[PAGE_BITS-1:0]] = byte_in;
                        next_l.mask[cur.addr[PAGE_BITS-1:0]] = 1'b1;
                        next_l.addr = {cur.addr[ADDR_W-1:PAGE_BITS],
                            cur.addr[PAGE_BITS-1:0] + 7'h1};
                    end else begin
                        next_l.phase = PH_SKIP;
                    end
                end
            end
            PH_OUT: begin
                next_l.bcnt = {1'b0, cur.bcnt[2:0] + 3'h1};
                if (cur.bcnt[2:0] == 3'h7 && cur.cmd == CMD_RD) begin
                    next_l.addr = cur.addr + 1'b1;
                end
            end
            default: begin
                next_l.bcnt = cur.bcnt;
            end
        endcase
    end

    always_ff @(posedge spi_sck) begin
        l <= next_l;
    end

    // Byte to shift out: status, or the corrected array byte at the read address.
    always_comb begin
        logic [DATA_BITS-1:0] rw;
        rw = ecc_fix(c.mem[l.addr[ADDR_W-1:2]]);
        out_byte = rw[{l.addr[1:0], 3'h0} +: 8];
        if (l.cmd == CMD_SRD) begin
            out_byte = status_view;
        end
    end

    // Output bits change on falling serial clock edges, most significant first.
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_so <= 1'b0;
            spi_so_oe <= 1'b0;
        end else begin
            spi_so <= out_byte[3'h7 - l.bcnt[2:0]];
            spi_so_oe <= in_frame && (l.phase == PH_OUT);
        end
    end

    assign cs_rise = c.cs2 & ~c.cs3;

    // Core side: commits a finished frame and runs the internal write cycle.
    always_comb begin
        logic [WA_W-1:0] widx;
        logic [DATA_BITS-1:0] wd;
        logic [PAGE_BITS-1:0] boff;
        widx = '0;
        wd = '0;
        boff = '0;
        next_c = c;
        next_c.cs1 = spi_cs_n;
        next_c.cs2 = c.cs1;
        next_c.cs3 = c.cs2;
        next_c.wp1 = wp_n;
        next_c.wp2 = c.wp1;
        if (c.busy) begin
            next_c.cnt = c.cnt - 1'b1;
            if (c.cnt == '0) begin
                next_c.busy = 1'b0;
                next_c.wen = 1'b0;
                if (c.pend_sr) begin
                    next_c.bp = c.new_bp;
                    next_c.arm = c.new_arm;
                end
            end
        end else if (cs_rise) begin
            case (l.cmd)
                CMD_SET: next_c.wen = 1'b1;
                CMD_CLR: next_c.wen = 1'b0;
                CMD_SWR: begin
                    if (l.got && c.wen && !(c.arm && !c.wp2)) begin
                        next_c.busy = 1'b1;
                        next_c.pend_sr = 1'b1;
                        next_c.cnt = CNT_W'(WR_CYC - 1);
                        next_c.new_bp = l.sh[ST_BP_LO +: 3];
                        next_c.new_arm = l.sh[ST_ARM] | (c.arm & ~c.wp2);
                    end
                end
                CMD_WR: begin
                    if (l.got && c.wen) begin
                        next_c.busy = 1'b1;
                        next_c.pend_sr = 1'b0;
                        next_c.cnt = CNT_W'(WR_CYC - 1);
                        for (int g = 0; g < PAGE_WORDS; g++) begin
                            widx = {l.addr[ADDR_W-1:PAGE_BITS], PW_BITS'(g)};
                            wd = ecc_fix(c.mem[widx]);
                            for (int b = 0; b < GROUP_BYTES; b++) begin
                                boff = PAGE_BITS'(g * GROUP_BYTES + b);
                                if (l.mask[boff]
                                    && !in_block({l.addr[ADDR_W-1:PAGE_BITS], boff}, c.bp)) begin
                                    wd[b * 8 +: 8] = l.pbuf[boff];
                                end
                            end
                            next_c.mem[widx] = {ecc_gen(wd), wd};
                        end
                    end
                end
                default: next_c.busy = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            c <= '0;
            c.cs1 <= 1'b1;
            c.cs2 <= 1'b1;
            c.cs3 <= 1'b1;
            c.wp1 <= 1'b1;
            c.wp2 <= 1'b1;
            c.wen <= RST_WEN;
            c.bp <= RST_BP;
            c.arm <= RST_ARM;
        end else begin
            c <= next_c;
        end
    end

    assign write_latch = c.wen;
    assign busy = c.busy;
    assign block_protect = c.bp;
    assign hw_protect_arm = c.arm;

    property p_wen_reset;
        @(posedge clock) disable iff (!rst_n) $rose(rst_n) |-> !write_latch;
    endproperty
    a_wen_reset: assert property (p_wen_reset) else $error("latch set after reset");
    property p_wen_set;
        @(posedge clock) disable iff (!rst_n)
            !c.busy && cs_rise && l.cmd == CMD_SET |=> write_latch;
    endproperty
    a_wen_set: assert property (p_wen_set) else $error("set command missed");
    property p_wen_clear;
        @(posedge clock) disable iff (!rst_n) c.busy && c.cnt == '0 |=> !write_latch && !busy;
    endproperty
    a_wen_clear: assert property (p_wen_clear) else $error("latch kept after cycle");
    property p_busy_view;
        @(posedge spi_sck) disable iff (!in_frame)
            spi_so_oe && l.cmd == CMD_SRD && busy |-> spi_so;
    endproperty
    a_busy_view: assert property (p_busy_view) else $error("busy status not all ones");
    property p_busy_ignores;
        @(posedge clock) disable iff (!rst_n) busy && c.cnt != '0 |=> $stable(write_latch);
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("command taken while busy");
    property p_sr_hold;
        @(posedge clock) disable iff (!rst_n)
            busy ##1 busy |-> $stable(block_protect) && $stable(hw_protect_arm);
    endproperty
    a_sr_hold: assert property (p_sr_hold) else $error("status changed mid cycle");
    property p_hw_lock;
        @(posedge clock) disable iff (!rst_n)
            !busy && cs_rise && l.cmd == CMD_SWR && c.arm && !c.wp2 |=> !busy;
    endproperty
    a_hw_lock: assert property (p_hw_lock) else $error("status write under protect");
    property p_no_latch;
        @(posedge clock) disable iff (!rst_n)
            !busy && cs_rise && l.cmd == CMD_WR && !write_latch |=> !busy;
    endproperty
    a_no_latch: assert property (p_no_latch) else $error("array write without latch");
    property p_cycle;
        @(posedge clock) disable iff (!rst_n) $rose(busy) |-> busy[*8];
    endproperty
    a_cycle: assert property (p_cycle) else $error("write cycle too short");
    property p_page_wrap;
        @(posedge spi_sck) disable iff (!in_frame)
            l.phase == PH_DATA && l.cmd == CMD_WR && l.bcnt[2:0] == 3'h7
            |=> l.addr[PAGE_BITS-1:0] == $past(l.addr[PAGE_BITS-1:0]) + 7'h1
            && l.addr[ADDR_W-1:PAGE_BITS] == $past(l.addr[ADDR_W-1:PAGE_BITS]);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page address wrap wrong");
endmodule // sec_eeprom
`default_nettype wire

// file: design/sec_pkg.sv
`default_nettype none
package sec_pkg;
    localparam int CLOCK_NS = 4;
    localparam int WRITE_CYCLE_NS = 5000;
    localparam int WR_CYCLES = (WRITE_CYCLE_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int ADDR_BITS = 16;
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_BITS = 7;
    localparam int GROUP_BYTES = 4;
    localparam int ECC_BITS = 6;
    localparam int DATA_BITS = 32;
    localparam logic [7:0] OPC_MASK = 8'hf7;
    localparam logic [7:0] OPC_SET = 8'h06;
    localparam logic [7:0] OPC_CLR = 8'h04;
    localparam logic [7:0] OPC_SRD = 8'h05;
    localparam logic [7:0] OPC_SWR = 8'h01;
    localparam logic [7:0] OPC_RD = 8'h03;
    localparam logic [7:0] OPC_WR = 8'h02;
    localparam int ST_BUSY = 0;
    localparam int ST_WEN = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_ARM = 7;
    localparam logic [7:0] ST_BUSY_VIEW = 8'hff;
    localparam logic RST_WEN = 1'b0;
    localparam logic [2:0] RST_BP = 3'h0;
    localparam logic RST_ARM = 1'b0;

    typedef enum logic [2:0] {CMD_NONE, CMD_SET, CMD_CLR, CMD_SRD, CMD_SWR, CMD_RD, CMD_WR} sec_cmd_t;
    typedef enum logic [2:0] {PH_OP, PH_ADDR, PH_DATA, PH_OUT, PH_SKIP} sec_phase_t;

    function automatic sec_cmd_t sec_decode(input logic [7:0] op);
        case (op & OPC_MASK)
            OPC_SET: return CMD_SET;
            OPC_CLR: return CMD_CLR;
            OPC_SRD: return CMD_SRD;
            OPC_SWR: return CMD_SWR;
            OPC_RD: return CMD_RD;
            OPC_WR: return CMD_WR;
            default: return CMD_NONE;
        endcase
    endfunction
endpackage
`default_nettype wire

// file: verification/sec_spi_master.sv
`timescale 1ns/1ns
`default_nettype none
module sec_spi_master #(
    parameter int HALF = 24
) (
    // Serial link.
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_si,
    input wire logic spi_so
);
    logic [7:0] rx[$];
    // A short select pulse clears the link frame marker, which has no reset of its own.
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b0;
        spi_si = 1'b0;
        #1;
        spi_cs_n = 1'b1;
    end
    // Shifts tx out MSB first plus nrx filler bytes and keeps every sampled byte.
    task automatic frame(input logic [7:0] tx[$], input int nrx);
        logic [7:0] s;
        s = 8'h00;
        rx = {};
        repeat (nrx) tx.push_back(8'($urandom_range(255)));
        #5;
        spi_cs_n = 1'b0;
        foreach (tx[i]) begin
            for (int k = 7; k >= 0; k--) begin
                spi_si = tx[i][k];
                #HALF;
                spi_sck = 1'b1;
                s = {s[6:0], spi_so};
                #HALF;
                spi_sck = 1'b0;
            end
            rx.push_back(s);
        end
        #(HALF / 2);
        spi_cs_n = 1'b1;
        spi_si = ~spi_si;
    endtask
endmodule // sec_spi_master
`default_nettype wire

// file: verification/sec_eeprom_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("mismatch at %0t: %h vs %h", $time, (g), (e)); end end
module sec_eeprom_tb;
    import sec_pkg::*;
    localparam int AW = 10;
    localparam int WC = 400;
    localparam int N = 2 ** AW;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic wp_n = 1'b1;
    wire logic spi_sck;
    wire logic spi_cs_n;
    wire logic spi_si;
    wire logic spi_so;
    wire logic spi_so_oe;
    wire logic write_latch;
    wire logic busy;
    wire logic [2:0] block_protect;
    wire logic hw_protect_arm;
    int errors = 0;
    int checks = 0;
    int run = 0;
    logic [7:0] mem [N];
    logic [7:0] q[$];
    logic [7:0] x3 = 8'h00;
    logic latch = 1'b0;
    logic [2:0] bp = 3'h0;
    logic arm = 1'b0;

    always #2 clock = ~clock;
    sec_eeprom #(.ADDR_W(AW), .WR_CYC(WC)) dut (
        .clock(clock), .rst_n(rst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .wp_n(wp_n),
        .write_latch(write_latch), .busy(busy), .block_protect(block_protect),
        .hw_protect_arm(hw_protect_arm)
    );
    sec_spi_master link (
        .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so)
    );

    always @(posedge clock) begin
        if (busy === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            `CHK(run, WC)
            run <= 0;
        end
    end

    function automatic bit prot(input int a);
        return (bp[1:0] == 2'h3) || (bp[1:0] == 2'h2 && a >= N / 2) ||
            (bp[1:0] == 2'h1 && a >= 3 * N / 4);
    endfunction
    function automatic logic [7:0] sview();
        return {arm, 2'h0, bp, latch, 1'b0};
    endfunction

    task automatic close_out();
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic send(input int nrx);
        link.frame(q, nrx);
        repeat (10) tick();
    endtask
    task automatic set_latch();
        q = {OPC_SET | x3};
        send(0);
        latch = 1'b1;
    endtask
    task automatic settle(input logic eb, input logic [3:0] nab, input logic nl);
        for (int i = 0; i < 12 && busy !== 1'b1; i++) tick();
        `CHK(busy, eb)
        `CHK({hw_protect_arm, block_protect, write_latch}, {arm, bp, latch})
        for (int i = 0; i < WC + 8 && busy === 1'b1; i++) tick();
        {arm, bp} = nab;
        latch = nl;
        `CHK({hw_protect_arm, block_protect, write_latch, busy}, {arm, bp, latch, 1'b0})
    endtask
    task automatic stat();
        q = {OPC_SRD | x3};
        send(2);
        `CHK(link.rx[1], sview())
        `CHK(link.rx[2], sview())
    endtask
    task automatic wr(input int a, input int nb, input bit en, input bit probe);
        logic acc;
        int x;
        if (en) set_latch();
        acc = latch;
        q = {OPC_WR | x3, 8'(a >> 8), 8'(a)};
        for (int i = 0; i < nb; i++) begin
            x = (a & ~127) | ((a + i) & 127);
            q.push_back(8'($urandom_range(255)));
            if (acc && !prot(x)) mem[x] = q[3 + i];
        end
        send(0);
        if (probe) begin
            q = {OPC_SRD | x3};
            send(1);
            `CHK(link.rx[1], ST_BUSY_VIEW)
            q = {OPC_SET | x3};
            send(0);
        end
        settle(acc, {arm, bp}, 1'b0);
    endtask
    task automatic rd(input int a, input int nb);
        q = {OPC_RD | x3, 8'(a >> 8), 8'(a)};
        send(nb);
        for (int k = 0; k < nb; k++) `CHK(link.rx[3 + k], mem[(a + k) % N])
        `CHK(spi_so_oe, 1'b0)
    endtask
    task automatic sw(input logic [7:0] v, input bit en);
        logic acc;
        if (en) set_latch();
        acc = latch && !(arm && !wp_n);
        q = {OPC_SWR | x3, v};
        send(0);
        settle(acc, acc ? {v[7], v[4:2]} : {arm, bp}, acc ? 1'b0 : latch);
    endtask

    initial begin
        #380000;
        errors++;
        close_out();
    end

    initial begin
        int a;
        void'($urandom(47867));
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (3) tick();
        `CHK({hw_protect_arm, block_protect, write_latch, busy, spi_so_oe}, 7'h00)
        stat();
        wr(16, 1, 1'b0, 1'b0);
        rd(16, 4);
        for (int i = 0; i < 2; i++) begin
            x3 = 8'(i * 8);
            set_latch();
            stat();
            q = {OPC_CLR | x3};
            send(0);
            latch = 1'b0;
            stat();
        end
        x3 = 8'h00;
        set_latch();
        q = {{4'($urandom_range(15, 1)), 4'($urandom_range(15))}, OPC_SET, OPC_WR};
        send(0);
        settle(1'b0, {arm, bp}, 1'b1);
        wr(N / 2 - 8, 130, 1'b1, 1'b0);
        rd(N / 2 - 128, 128);
        rd(N - 2, 4);
        for (int i = 0; i < 4; i++) begin
            a = $urandom_range(N - 1);
            wr(a, $urandom_range(4, 1), 1'b1, i == 0);
            rd(a & ~3, 4);
        end
        x3 = 8'h08;
        sw(8'h0c, 1'b0);
        for (int lv = 1; lv < 4; lv++) begin
            sw({1'b0, 2'($urandom), 1'($urandom), 2'(lv), 2'($urandom)}, 1'b1);
            for (int j = 0; j < 3; j++) begin
                a = N / 4 + j * N / 4 + 9;
                wr(a, 2, 1'b1, 1'b0);
                rd(a, 2);
            end
        end
        sw(8'h84, 1'b1);
        tick();
        wp_n = 1'b0;
        sw(8'h00, 1'b1);
        wr(17, 2, 1'b0, 1'b0);
        rd(17, 2);
        tick();
        wp_n = 1'b1;
        sw(8'h00, 1'b1);
        stat();
        close_out();
    end
endmodule // sec_eeprom_tb
`default_nettype wire
